// ---- rfx_map.svh ----
`ifndef RFX_MAP_SVH
`define RFX_MAP_SVH

// ****************************************
// Radio end register offsets (link addr)
// ****************************************
`define RFX_REG_MODE 4'h0
`define RFX_REG_TXCFG 4'h1
`define RFX_REG_TXPWR 4'h2
`define RFX_REG_DECIM 4'h3
`define RFX_REG_RGAIN 4'h4
`define RFX_REG_MODUL 4'h5
`define RFX_REG_FDEV 4'h6
`define RFX_REG_TX_BIT_RATE_SETTING 4'h7
`define RFX_REG_ENC 4'h8
`define RFX_REG_FDATA 4'h9
`define RFX_REG_FCOUNT 4'hA
`define RFX_REG_FSTAT 4'hB
`define RFX_REG_FTHR 4'hC
`define RFX_REG_IMASK 4'hD

// ****************************************
// Field positions
// ****************************************
`define RFX_MODE_TX 0
`define RFX_MODE_RAW 1
`define RFX_TXCFG_DIFF 0
`define RFX_TXCFG_SE 1
`define RFX_TXCFG_SHAPE 2
`define RFX_TXCFG_RAMP_LSB 3
`define RFX_ENC_INV 0
`define RFX_ENC_DIFF 1
`define RFX_ENC_MANCH 2
`define RFX_ENC_WHITEN 3
`define RFX_ST_EMPTY 0
`define RFX_ST_NEMPTY 1
`define RFX_ST_FULL 2
`define RFX_ST_NFULL 3
`define RFX_ST_LEVEL 4

// ****************************************
// Reset values and codes
// ****************************************
`define RFX_RST_TXCFG 8'h05
`define RFX_RST_TX_BIT_RATE_SETTING 8'h07
`define RFX_RST_FTHR 8'h80
`define RFX_MOD_ASK 8'h00
`define RFX_FLAG 8'h7E
`define RFX_CHUNK_HDR 8'h21
`define RFX_SCR_TAP_A 4
`define RFX_SCR_TAP_B 8
`define RFX_FIFO_DEPTH 9'h100

// ****************************************
// Controller APB offsets
// ****************************************
`define RFX_APB_CMD 8'h00
`define RFX_APB_STATUS 8'h04
`define RFX_APB_DMA 8'h08
`define RFX_CMD_WRITE 12
`define RFX_DMA_TX_EN 0
`define RFX_DMA_RX_EN 1

`endif

// ---- rfx_pkg.sv ----
package rfx_pkg;
  typedef enum logic [2:0] {
    TS_IDLE = 3'b001,
    TS_DATA = 3'b010,
    TS_END = 3'b100
  } rfx_txst_e;

  typedef enum logic [2:0] {
    SRC_CPU = 3'b001,
    SRC_DTX = 3'b010,
    SRC_DRX = 3'b100
  } rfx_src_e;

  typedef enum logic [1:0] {
    C_IDLE = 2'b01,
    C_WAIT = 2'b10
  } rfx_cst_e;
endpackage : rfx_pkg

// ---- rfx_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rfx_link_if;
  logic req;
  logic we;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic [4:0] status;
  logic irq;

  modport dev (
    input req,
    input we,
    input addr,
    input wdata,
    output ack,
    output rdata,
    output status,
    output irq
  );

  modport ctl (
    output req,
    output we,
    output addr,
    output wdata,
    input ack,
    input rdata,
    input status,
    input irq
  );
endinterface : rfx_link_if
`default_nettype wire

// ---- rfx_radio_end.sv ----
// Chosen here: the link slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rfx_map.svh"

// Contract
// - Two select bits route PA output
// - Power coefficient sets PA level
// - Shape bit gives raised-cosine amplitude
// - Ramp lasts one to eight bits
// - Channel_filter_decim setting programs channel filter bandwidth
// - One modulation setting for TX and RX
// - Timing and datarate gains programmable
// - Deviation and bit rate programmable
// - Invert option flips every bit
// - Differential: one toggles, zero holds
// - Manchester doubles line rate
// - Self-synchronizing whitening, no extra bits
// - Packet or raw framing both ways
// - All payload through one 256-byte FIFO
// - FIFO holds chunks with length/type header
// - FIFO direction follows transmit or receive
// - Polling host reads status or count
// - Empty, not empty, full, not full, level sources
// - Interrupts clear only when cause disappears
// - DMA may replace processor FIFO access
module rfx_radio_end (
  input wire logic pclk,
  input wire logic presetn,
  rfx_link_if.dev link,
  input wire logic rx_line,
  output logic tx_line,
  output logic tx_differential_out_sel,
  output logic tx_single_ended_out_sel,
  output logic [7:0] pa_level,
  output logic [7:0] channel_filter_decim,
  output logic [3:0] timing_recovery_gain,
  output logic [3:0] datarate_recovery_gain,
  output logic [7:0] modulation_sel,
  output logic [7:0] freq_deviation_setting,
  output logic [7:0] tx_bit_rate_setting
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_cfg(input logic [3:0] a);
    is_cfg = (a <= `RFX_REG_ENC) || (a == `RFX_REG_FTHR) || (a == `RFX_REG_IMASK);
  endfunction : is_cfg

  function automatic logic [7:0] rst_val(input int i);
    case (i)
      1: rst_val = `RFX_RST_TXCFG;
      7: rst_val = `RFX_RST_TX_BIT_RATE_SETTING;
      12: rst_val = `RFX_RST_FTHR;
      default: rst_val = 8'h00;
    endcase
  endfunction : rst_val

  // Linear ramp weight, optionally bent to a raised-cosine-like smoothstep
  function automatic logic [7:0] ramp_weight(input logic [3:0] k, input logic [3:0] len,
                                             input logic shape);
    logic [31:0] x;
    logic [31:0] s;
    x = (32'(k) * 32'd256) / 32'(len);
    s = (32'd3 * x * x - ((32'd2 * x * x * x) >> 8)) >> 8;
    if (!shape) s = x;
    ramp_weight = (s > 32'd255) ? 8'hFF : s[7:0];
  endfunction : ramp_weight

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] cfg_q [0:15];
  logic [7:0] cfg_d [0:15];
  logic wr_cfg;
  logic tx_mode, raw_mode, inv_en, diff_en, manch_en, whiten_en;
  logic [3:0] ramp_len;

  assign wr_cfg = link.req & link.we & is_cfg(link.addr);
  assign tx_mode = cfg_q[`RFX_REG_MODE][`RFX_MODE_TX];
  assign raw_mode = cfg_q[`RFX_REG_MODE][`RFX_MODE_RAW];
  assign inv_en = cfg_q[`RFX_REG_ENC][`RFX_ENC_INV];
  assign diff_en = cfg_q[`RFX_REG_ENC][`RFX_ENC_DIFF];
  assign manch_en = cfg_q[`RFX_REG_ENC][`RFX_ENC_MANCH];
  assign whiten_en = cfg_q[`RFX_REG_ENC][`RFX_ENC_WHITEN];
  assign ramp_len = {1'b0, cfg_q[`RFX_REG_TXCFG][`RFX_TXCFG_RAMP_LSB +: 3]} + 4'h1;
  assign tx_differential_out_sel = cfg_q[`RFX_REG_TXCFG][`RFX_TXCFG_DIFF];
  assign tx_single_ended_out_sel = cfg_q[`RFX_REG_TXCFG][`RFX_TXCFG_SE];
  assign channel_filter_decim = cfg_q[`RFX_REG_DECIM];
  assign timing_recovery_gain = cfg_q[`RFX_REG_RGAIN][3:0];
  assign datarate_recovery_gain = cfg_q[`RFX_REG_RGAIN][7:4];
  assign modulation_sel = cfg_q[`RFX_REG_MODUL];
  assign freq_deviation_setting = cfg_q[`RFX_REG_FDEV];
  assign tx_bit_rate_setting = cfg_q[`RFX_REG_TX_BIT_RATE_SETTING];

  always_comb begin
    for (int i = 0; i < 16; i++) cfg_d[i] = cfg_q[i];
    if (wr_cfg) cfg_d[link.addr] = link.wdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) cfg_q[i] <= rst_val(i);
    end else begin
      for (int i = 0; i < 16; i++) cfg_q[i] <= cfg_d[i];
    end
  end

  // ****************************************
  // FIFO
  // ****************************************
  logic [7:0] mem [0:255];
  logic [7:0] wr_q, wr_d, rd_q, rd_d;
  logic [8:0] cnt_q, cnt_d;
  logic empty, full, flush, host_push, host_pop, radio_push, radio_pop, push, pop;
  logic [7:0] push_data, fifo_out, rx_hdr_or_byte;

  assign empty = (cnt_q == 9'h000);
  assign full = (cnt_q == `RFX_FIFO_DEPTH);
  assign fifo_out = mem[rd_q];
  // Direction change flushes so stale TX bytes never appear as RX data
  assign flush = link.req & link.we & (link.addr == `RFX_REG_MODE)
                 & (link.wdata[`RFX_MODE_TX] != tx_mode);
  // host fills in TX, drains in RX
  assign host_push = link.req & link.we & (link.addr == `RFX_REG_FDATA) & tx_mode & !full;
  assign host_pop = link.req & !link.we & (link.addr == `RFX_REG_FDATA) & !tx_mode & !empty;
  assign push = host_push | radio_push;
  assign pop = host_pop | radio_pop;
  assign push_data = tx_mode ? link.wdata : rx_hdr_or_byte;

  always_comb begin
    wr_d = push ? wr_q + 8'h01 : wr_q;
    rd_d = pop ? rd_q + 8'h01 : rd_q;
    cnt_d = cnt_q + {8'h00, push} - {8'h00, pop};
    if (flush) begin
      wr_d = 8'h00;
      rd_d = 8'h00;
      cnt_d = 9'h000;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) mem[wr_q] <= push_data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 8'h00;
      rd_q <= 8'h00;
      cnt_q <= 9'h000;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************
  // Link answer and status
  // ****************************************
  logic ack_d, ack_q, irq_d, irq_q;
  logic [7:0] rdata_d, rdata_q;
  logic [4:0] stat_d, stat_q;
  logic lvl_hit;

  always_comb begin
    lvl_hit = tx_mode ? (cnt_d <= {1'b0, cfg_d[`RFX_REG_FTHR]})
                      : (cnt_d >= {1'b0, cfg_d[`RFX_REG_FTHR]});
    // pure levels of count, no acknowledge
    stat_d[`RFX_ST_EMPTY] = (cnt_d == 9'h000);
    stat_d[`RFX_ST_NEMPTY] = (cnt_d != 9'h000);
    stat_d[`RFX_ST_FULL] = (cnt_d == `RFX_FIFO_DEPTH);
    stat_d[`RFX_ST_NFULL] = (cnt_d != `RFX_FIFO_DEPTH);
    stat_d[`RFX_ST_LEVEL] = lvl_hit;
    irq_d = |(stat_d & cfg_d[`RFX_REG_IMASK][4:0]);
    ack_d = link.req;
    rdata_d = 8'h00;
    if (link.req && !link.we) begin
      case (link.addr)
        `RFX_REG_FDATA: rdata_d = host_pop ? fifo_out : 8'h00;
        `RFX_REG_FCOUNT: rdata_d = cnt_q[7:0];
        `RFX_REG_FSTAT: rdata_d = {3'h0, stat_q};
        default: rdata_d = is_cfg(link.addr) ? cfg_q[link.addr] : 8'h00;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      stat_q <= 5'h09;
      irq_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end

  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign link.status = stat_q;
  assign link.irq = irq_q;

  // ****************************************
  // Bit timing, framing and encoder
  // ****************************************
  logic [7:0] div_q, div_d, sh_q, sh_d, nb, nsh, byte_q, byte_d;
  logic [2:0] bc_q, bc_d;
  logic [4:0] len_q, len_d;
  logic [8:0] scr_q, scr_d;
  logic [1:0] pend_q, pend_d;
  logic [3:0] k_q, k_d;
  logic [7:0] pa_d, pa_q;
  logic phase_q, phase_d, tick, step, need, dbit, w, e, lvl_q, lvl_d, enc_q, enc_d;
  logic line_q, line_d, a, d, x, inframe_q, inframe_d, sync1_q, sync2_q;
  logic [15:0] prod;
  rfx_pkg::rfx_txst_e st_q, st_d;

  assign tick = (div_q == 8'h00);
  // with Manchester on, one data bit per two line symbols; otherwise one per symbol
  assign step = tick & (!manch_en | !phase_q);
  assign need = step & tx_mode & (bc_q == 3'h0);
  assign rx_hdr_or_byte = pend_q[1] ? `RFX_CHUNK_HDR : byte_q;
  assign radio_push = !tx_mode & (pend_q != 2'b00) & !full;

  always_comb begin
    div_d = tick ? cfg_q[`RFX_REG_TX_BIT_RATE_SETTING] : div_q - 8'h01;
    phase_d = manch_en & (tick ? !phase_q : phase_q);
    nb = 8'h00;
    radio_pop = 1'b0;
    st_d = st_q;
    len_d = len_q;
    // packet mode unwraps chunk header into flagged frame
    if (need) begin
      if (raw_mode) begin
        radio_pop = !empty;
        nb = empty ? 8'h00 : fifo_out;
      end else begin
        case (st_q)
          rfx_pkg::TS_IDLE: if (!empty) begin
            radio_pop = 1'b1;
            len_d = fifo_out[4:0];
            nb = `RFX_FLAG;
            st_d = (fifo_out[4:0] == 5'h00) ? rfx_pkg::TS_END : rfx_pkg::TS_DATA;
          end
          rfx_pkg::TS_DATA: begin
            radio_pop = !empty;
            nb = empty ? 8'h00 : fifo_out;
            len_d = len_q - 5'h01;
            if (len_q == 5'h01) st_d = rfx_pkg::TS_END;
          end
          rfx_pkg::TS_END: begin
            nb = `RFX_FLAG;
            st_d = rfx_pkg::TS_IDLE;
          end
          default: st_d = rfx_pkg::TS_IDLE;
        endcase
      end
    end
    dbit = need ? nb[0] : sh_q[0];
    w = whiten_en ? (dbit ^ scr_q[`RFX_SCR_TAP_A] ^ scr_q[`RFX_SCR_TAP_B]) : dbit;
    e = (diff_en ? (lvl_q ^ w) : w) ^ inv_en;
    a = sync2_q ^ inv_en;
    d = diff_en ? (a ^ lvl_q) : a;
    x = whiten_en ? (d ^ scr_q[`RFX_SCR_TAP_A] ^ scr_q[`RFX_SCR_TAP_B]) : d;
    nsh = {x, sh_q[7:1]};
    sh_d = sh_q;
    bc_d = bc_q;
    scr_d = scr_q;
    lvl_d = lvl_q;
    enc_d = enc_q;
    line_d = tx_mode ? line_q : 1'b0;
    inframe_d = inframe_q;
    byte_d = byte_q;
    pend_d = pend_q[1] ? 2'b01 : 2'b00;
    if (step && tx_mode) begin
      sh_d = need ? {1'b0, nb[7:1]} : {1'b0, sh_q[7:1]};
      bc_d = bc_q - 3'h1;
      scr_d = {scr_q[7:0], w};
      lvl_d = diff_en ? (lvl_q ^ w) : lvl_q;
      enc_d = e;
      line_d = e;
    end else if (tick && tx_mode && manch_en) begin
      // second half symbol is the complement
      line_d = !enc_q;
    end else if (step) begin
      sh_d = nsh;
      scr_d = {scr_q[7:0], d};
      lvl_d = a;
      if (raw_mode || inframe_q) begin
        bc_d = bc_q + 3'h1;
        if (bc_q == 3'h7 && !(!raw_mode && nsh == `RFX_FLAG)) begin
          byte_d = nsh;
          // each received packet byte gets its own data chunk
          pend_d = raw_mode ? 2'b01 : 2'b11;
        end
      end else if (nsh == `RFX_FLAG) begin
        inframe_d = 1'b1;
        bc_d = 3'h0;
      end
    end
    if (flush) begin
      bc_d = 3'h0;
      st_d = rfx_pkg::TS_IDLE;
      inframe_d = 1'b0;
      pend_d = 2'b00;
    end
    k_d = k_q;
    if (step && tx_mode && k_q < ramp_len) k_d = k_q + 4'h1;
    if (step && !tx_mode && k_q != 4'h0) k_d = k_q - 4'h1;
    if (k_q > ramp_len) k_d = ramp_len;
    // level is coefficient times ramp weight
    prod = 16'(cfg_q[`RFX_REG_TXPWR]) *
           16'(ramp_weight(k_q, ramp_len, cfg_q[`RFX_REG_TXCFG][`RFX_TXCFG_SHAPE]));
    pa_d = prod[15:8];
    // ASK keys the PA off for a low line level
    if (cfg_q[`RFX_REG_MODUL] == `RFX_MOD_ASK && !line_q) pa_d = 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      phase_q <= 1'b0;
      sh_q <= 8'h00;
      bc_q <= 3'h0;
      len_q <= 5'h00;
      st_q <= rfx_pkg::TS_IDLE;
      scr_q <= 9'h000;
      lvl_q <= 1'b0;
      enc_q <= 1'b0;
      line_q <= 1'b0;
      inframe_q <= 1'b0;
      byte_q <= 8'h00;
      pend_q <= 2'b00;
      k_q <= 4'h0;
      pa_q <= 8'h00;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      div_q <= div_d;
      phase_q <= phase_d;
      sh_q <= sh_d;
      bc_q <= bc_d;
      len_q <= len_d;
      st_q <= st_d;
      scr_q <= scr_d;
      lvl_q <= lvl_d;
      enc_q <= enc_d;
      line_q <= line_d;
      inframe_q <= inframe_d;
      byte_q <= byte_d;
      pend_q <= pend_d;
      k_q <= k_d;
      pa_q <= pa_d;
      sync1_q <= rx_line;
      sync2_q <= sync1_q;
    end
  end

  assign tx_line = line_q;
  assign pa_level = pa_q;
endmodule : rfx_radio_end
`default_nettype wire

// ---- rfx_ctl_end.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rfx_map.svh"

module rfx_ctl_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dma_tx_valid,
  input wire logic [7:0] dma_tx_data,
  output logic dma_tx_ready,
  output logic dma_rx_valid,
  output logic [7:0] dma_rx_data,
  rfx_link_if.ctl link
);
  // ****************************************
  // State
  // ****************************************
  rfx_pkg::rfx_cst_e st_q, st_d;
  rfx_pkg::rfx_src_e src_q, src_d;
  logic req_q, req_d, we_q, we_d, rdy_q, rdy_d, err_q, err_d;
  logic [3:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d, rd_q, rd_d, rxd_q, rxd_d;
  logic [31:0] prdata_q, prdata_d;
  logic [1:0] dma_q, dma_d;
  logic txr_q, txr_d, rxv_q, rxv_d, setup, wr_done, cmd_go;

  assign setup = psel & !penable;
  assign wr_done = psel & penable & rdy_q & pwrite;
  assign cmd_go = wr_done & (paddr == `RFX_APB_CMD);

  always_comb begin
    st_d = st_q;
    src_d = src_q;
    req_d = 1'b0;
    we_d = we_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rd_d = rd_q;
    rxd_d = rxd_q;
    txr_d = 1'b0;
    rxv_d = 1'b0;
    dma_d = dma_q;
    rdy_d = setup;
    err_d = setup & (paddr != `RFX_APB_CMD) & (paddr != `RFX_APB_STATUS)
            & (paddr != `RFX_APB_DMA);
    prdata_d = prdata_q;
    if (setup) begin
      case (paddr)
        `RFX_APB_STATUS: prdata_d = {10'h000, link.irq, link.status, rd_q, 7'h00,
                                     st_q == rfx_pkg::C_WAIT};
        `RFX_APB_DMA: prdata_d = {30'h0, dma_q};
        default: prdata_d = 32'h0;
      endcase
    end
    if (wr_done && paddr == `RFX_APB_DMA) dma_d = pwdata[1:0];
    case (st_q)
      rfx_pkg::C_IDLE: begin
        // Processor command wins over DMA
        if (cmd_go) begin
          req_d = 1'b1;
          we_d = pwdata[`RFX_CMD_WRITE];
          addr_d = pwdata[11:8];
          wdata_d = pwdata[7:0];
          src_d = rfx_pkg::SRC_CPU;
          st_d = rfx_pkg::C_WAIT;
        end else if (dma_q[`RFX_DMA_TX_EN] && dma_tx_valid
                     && link.status[`RFX_ST_NFULL]) begin
          // DMA fills FIFO in place of processor
          req_d = 1'b1;
          we_d = 1'b1;
          addr_d = `RFX_REG_FDATA;
          wdata_d = dma_tx_data;
          txr_d = 1'b1;
          src_d = rfx_pkg::SRC_DTX;
          st_d = rfx_pkg::C_WAIT;
        end else if (dma_q[`RFX_DMA_RX_EN] && link.status[`RFX_ST_NEMPTY]) begin
          req_d = 1'b1;
          we_d = 1'b0;
          addr_d = `RFX_REG_FDATA;
          src_d = rfx_pkg::SRC_DRX;
          st_d = rfx_pkg::C_WAIT;
        end
      end
      rfx_pkg::C_WAIT: begin
        if (link.ack) begin
          rd_d = link.rdata;
          if (src_q == rfx_pkg::SRC_DRX) begin
            rxv_d = 1'b1;
            rxd_d = link.rdata;
          end
          st_d = rfx_pkg::C_IDLE;
        end
      end
      default: st_d = rfx_pkg::C_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= rfx_pkg::C_IDLE;
      src_q <= rfx_pkg::SRC_CPU;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 4'h0;
      wdata_q <= 8'h00;
      rd_q <= 8'h00;
      rxd_q <= 8'h00;
      txr_q <= 1'b0;
      rxv_q <= 1'b0;
      dma_q <= 2'b00;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      st_q <= st_d;
      src_q <= src_d;
      req_q <= req_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rd_q <= rd_d;
      rxd_q <= rxd_d;
      txr_q <= txr_d;
      rxv_q <= rxv_d;
      dma_q <= dma_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      prdata_q <= prdata_d;
    end
  end

  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign prdata = prdata_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign dma_tx_ready = txr_q;
  assign dma_rx_valid = rxv_q;
  assign dma_rx_data = rxd_q;
endmodule : rfx_ctl_end
`default_nettype wire

// ---- rfx_link_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module rfx_link_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic [4:0] status,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Reset may only land at the first edge, so flags settle from the second
  logic rst_seen_q;

  always_ff @(posedge pclk) begin
    rst_seen_q <= !presetn;
  end

  // ****************************************
  // Link handshake
  // ****************************************
  req_gets_ack_a: assert property (req |=> ack)
    else $error("link ack missing one cycle after req");
  ack_has_req_a: assert property (ack |-> $past(req))
    else $error("link ack without a request");
  req_spacing_a: assert property (req |=> !req)
    else $error("link req pulses back to back");
  write_rdata_zero_a: assert property (ack && $past(we) |-> rdata == 8'h00)
    else $error("link rdata not zero on write ack");

  // ****************************************
  // FIFO flags
  // ****************************************
  empty_pair_a: assert property (status[0] != status[1])
    else $error("empty and not empty disagree");
  full_pair_a: assert property (status[2] != status[3])
    else $error("full and not full disagree");
  empty_not_full_a: assert property (status[0] |-> status[3] && !status[2])
    else $error("fifo empty and full together");
  // Own disable so it is live during reset
  reset_flags_a: assert property (disable iff (1'b0)
    !presetn && rst_seen_q |-> status == 5'h09 && !irq)
    else $error("flags wrong during reset");

  cover property (req && we && addr == 4'h9);
  cover property (status[2]);
  cover property (irq);
endmodule : rfx_link_assertions
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, dma_tx_valid = 1'b0, dma_tx_ready, dma_rx_valid;
  logic [7:0] dma_tx_data = 8'h00;
  logic [7:0] dma_rx_data;
  logic rx_bit = 1'b0;
  logic tx_line, tx_differential_out_sel, tx_single_ended_out_sel;
  logic [7:0] pa_level, channel_filter_decim, modulation_sel;
  logic [7:0] freq_deviation_setting, tx_bit_rate_setting;
  logic [3:0] timing_recovery_gain, datarate_recovery_gain;
  int fails = 0;
  int cmp_count = 0;
  // Last row leaves a slow line rate so the FIFO drains slowly
  logic [3:0] ra [7] = '{4'h1, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  logic [7:0] rv [7] = '{8'h02, 8'h01, 8'h5A, 8'hC3, 8'h01, 8'h3C, 8'hFF};

  always #4 pclk = ~pclk;

  rfx_link_if u_rfx_link_if ();
  rfx_ctl_end u_rfx_ctl_end (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_tx_valid(dma_tx_valid),
    .dma_tx_data(dma_tx_data), .dma_tx_ready(dma_tx_ready), .dma_rx_valid(dma_rx_valid),
    .dma_rx_data(dma_rx_data), .link(u_rfx_link_if));
  // Receive line comes from the bench: tx_line is held low whenever RX runs
  rfx_radio_end u_rfx_radio_end (.pclk(pclk), .presetn(presetn), .link(u_rfx_link_if),
    .rx_line(rx_bit), .tx_line(tx_line),
    .tx_differential_out_sel(tx_differential_out_sel),
    .tx_single_ended_out_sel(tx_single_ended_out_sel), .pa_level(pa_level),
    .channel_filter_decim(channel_filter_decim), .timing_recovery_gain(timing_recovery_gain),
    .datarate_recovery_gain(datarate_recovery_gain), .modulation_sel(modulation_sel),
    .freq_deviation_setting(freq_deviation_setting),
    .tx_bit_rate_setting(tx_bit_rate_setting));
  rfx_link_assertions u_rfx_link_assertions (.pclk(pclk), .presetn(presetn),
    .req(u_rfx_link_if.req), .we(u_rfx_link_if.we), .addr(u_rfx_link_if.addr),
    .wdata(u_rfx_link_if.wdata), .ack(u_rfx_link_if.ack), .rdata(u_rfx_link_if.rdata),
    .status(u_rfx_link_if.status), .irq(u_rfx_link_if.irq));

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rdv, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No limit here: a hung slave is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Issue one link access, then poll until the controller is idle
  task automatic cmd(input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [31:0] st);
    logic e;
    apb(1'b1, 8'h00, {19'h0, w, a, d}, st, e);
    do begin
      apb(1'b0, 8'h04, 32'h0, st, e);
    end while (st[0] !== 1'b0);
  endtask : cmd

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] port_of(input logic [3:0] a);
    case (a)
      4'h1: port_of = {6'h0, tx_single_ended_out_sel, tx_differential_out_sel};
      4'h3: port_of = channel_filter_decim;
      4'h4: port_of = {datarate_recovery_gain, timing_recovery_gain};
      4'h5: port_of = modulation_sel;
      4'h6: port_of = freq_deviation_setting;
      default: port_of = tx_bit_rate_setting;
    endcase
  endfunction : port_of

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // ****************************************
  // Tests
  // ****************************************
  initial begin : main
    logic [31:0] st;
    logic e;
    int n;
    int k;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0, st, e);
    chk("reset status", 32'h0009_0000, st & 32'h003F_0001);
    chk("reset ports", 32'h0002_0700, {14'h0, tx_differential_out_sel,
      tx_single_ended_out_sel, tx_bit_rate_setting, pa_level});
    apb(1'b0, 8'hFC, 32'h0, st, e);
    chk("unmapped", 32'h8000_0000, {e, st[30:0]});
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      cmd(1'b1, ra[i], rv[i], st);
      chk("config port", (ra[i] == 4'h1) ? {30'h0, rv[i][1:0]} : {24'h0, rv[i]},
        {24'h0, port_of(ra[i])});
    end
    $display("test config table done");
    cmd(1'b1, 4'h9, 8'hA5, st);
    cmd(1'b0, 4'hA, 8'h00, st);
    chk("rx mode write", 32'h0009_0000, st & 32'h003F_FF00);
    $display("test rx refusal done");
    cmd(1'b1, 4'h2, 8'hFF, st);
    cmd(1'b1, 4'h8, 8'h04, st);
    cmd(1'b1, 4'h0, 8'h01, st);
    apb(1'b1, 8'h08, 32'h1, st, e);
    dma_tx_valid <= 1'b1;
    n = 0;
    k = 0;
    while (u_rfx_link_if.status[2] !== 1'b1 && k < 4000) begin
      @(posedge pclk);
      k++;
      if (dma_tx_ready === 1'b1) begin
        n++;
        dma_tx_data <= dma_tx_data + 8'h01;
      end
    end
    dma_tx_valid <= 1'b0;
    apb(1'b1, 8'h08, 32'h0, st, e);
    chk("bytes taken", 32'h1, {31'h0, n >= 256 && n <= 258});
    cmd(1'b1, 4'hD, 8'h04, st);
    cmd(1'b0, 4'hA, 8'h00, st);
    chk("full status", 32'h0026_0000, st & 32'h003F_FF00);
    // One-bit ramp is complete long before the FIFO fills
    chk("pa level", 32'h0000_00FE, {24'h0, pa_level});
    // Leaving TX flushes, which must drop the full source
    cmd(1'b1, 4'h0, 8'h00, st);
    chk("flushed status", 32'h0009_0000, st & 32'h003F_0000);
    $display("test fifo fill done");
    // Constant high line gives all-ones bytes whatever the bit alignment
    rx_bit <= 1'b1;
    cmd(1'b1, 4'h0, 8'h02, st);
    apb(1'b1, 8'h08, 32'h2, st, e);
    k = 0;
    while (dma_rx_valid !== 1'b1 && k < 6000) begin
      @(posedge pclk);
      k++;
    end
    chk("dma rx byte", 32'h0000_00FF, {24'h0, dma_rx_data});
    $display("test raw rx done");
    final_report();
  end

  initial begin : watchdog
    repeat (30000) @(posedge pclk);
    fails++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
